// [design/acfgtp_pattern_gen.sv]
`timescale 1ns/1ps
module acfgtp_pattern_gen
  import acfgtp_pkg::*;
#(
  parameter int SAMPLE_W = 14
)
(
  // clock and control
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ce,
  // configuration
  input  wire logic [2:0]            i_sel,
  input  wire logic [ACFG_PAT_W-1:0] i_value,
  // sample stream
  input  wire logic [SAMPLE_W-1:0]   i_sample,
  output logic      [ACFG_PAT_W-1:0] o_data
);
  // ==========================================================
  // ramp accumulator and output register
  logic [ACFG_PAT_W-1:0] ramp_q;
  logic [ACFG_PAT_W-1:0] ramp_d;
  logic [ACFG_PAT_W-1:0] data_q;
  logic [ACFG_PAT_W-1:0] data_d;

  always_comb
  begin
    ramp_d = ramp_q;
    data_d = {i_sample, {(ACFG_PAT_W-SAMPLE_W){1'b0}}};
    case (i_sel)
      ACFG_PAT_NORMAL:
      begin
        ramp_d = '0;
      end
      ACFG_PAT_RAMP:
      begin
        // value is the step; msb-aligned so 10000 steps 14-bit lsb
        ramp_d = ramp_q + i_value;
        data_d = ramp_q;
      end
      ACFG_PAT_CONST:
      begin
        data_d = i_value;
      end
      default:
      begin
        // unused codes pass samples, the safest choice
        ramp_d = '0;
      end
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      ramp_q <= '0;
      data_q <= '0;
    end
    else if (i_ce)
    begin
      ramp_q <= ramp_d;
      data_q <= data_d;
    end
  end

  assign o_data = data_q;

  // ==========================================================
  // checks
  sequence s_ramp_cycle;
    i_ce && i_sel == ACFG_PAT_RAMP;
  endsequence

  // constant mode keeps the accumulator, so only these codes clear it
  sequence s_ramp_idle;
    i_ce && i_sel != ACFG_PAT_RAMP && i_sel != ACFG_PAT_CONST;
  endsequence

  chk_const_value: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sel == ACFG_PAT_CONST |=> o_data == $past(i_value))
    else $error("constant pattern mismatch");
  chk_ramp_start: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    s_ramp_idle ##1 s_ramp_cycle |=> o_data == '0)
    else $error("ramp did not start at zero");
  chk_ramp_step: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    s_ramp_cycle ##1 s_ramp_cycle
    |=> o_data == $past(o_data) + $past(i_value, 2))
    else $error("ramp step mismatch");
  chk_normal_pass: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && i_sel == ACFG_PAT_NORMAL
    |=> o_data[ACFG_PAT_W-1 -: SAMPLE_W] == $past(i_sample))
    else $error("normal samples not passed");
  chk_unused_pass: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !(i_sel inside {ACFG_PAT_NORMAL, ACFG_PAT_RAMP, ACFG_PAT_CONST})
    |=> o_data[ACFG_PAT_W-1 -: SAMPLE_W] == $past(i_sample))
    else $error("unused code did not pass samples");
endmodule : acfgtp_pattern_gen

// [design/acfgtp_pkg.sv]
package acfgtp_pkg;
  // ==========================================================
  // register offsets
  localparam logic [7:0] ACFG_OFF_ANALOG = 8'h11;
  localparam logic [7:0] ACFG_OFF_LOAD   = 8'h13;
  localparam logic [7:0] ACFG_OFF_PAT_LO = 8'h14;
  localparam logic [7:0] ACFG_OFF_PAT_MI = 8'h15;
  localparam logic [7:0] ACFG_OFF_PAT_HI = 8'h16;
  // ==========================================================
  // field positions
  localparam int ACFG_BIT_SE       = 5;
  localparam int ACFG_BIT_LOOP_OFF = 2;
  localparam int ACFG_BIT_AZ       = 0;
  localparam int ACFG_BIT_LOAD     = 0;
  localparam int ACFG_SEL_LSB      = 2;
  localparam int ACFG_SEL_MSB      = 4;
  localparam int ACFG_PAT_W        = 18;
  // ==========================================================
  // reset values
  localparam logic [7:0] ACFG_RST_ZERO = 8'h00;
  // ==========================================================
  // pattern select codes
  typedef enum logic [2:0]
  {
    ACFG_PAT_NORMAL = 3'b000,
    ACFG_PAT_RAMP   = 3'b010,
    ACFG_PAT_CONST  = 3'b011
  } acfg_pat_sel_t;
  // ==========================================================
  // register write request
  typedef struct packed
  {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
  } acfg_wr_t;
endpackage : acfgtp_pkg

// [design/acfgtp_regs.sv]
`timescale 1ns/1ps
// Behaviour
// - select 000 normal, 010 ramp, 011 constant
// - constant outputs 18-bit value from three bytes
// - ramp uses value as increment step
// - pattern inserted before mapper, msb aligned
// - mapping load clears other configuration registers
// - bit 5 selects single-ended input
// - bit 2 turns off sampling-time loop
// - bit 0 auto-zero, variant-dependent reset
module acfgtp_regs
  import acfgtp_pkg::*;
#(
  parameter int         SAMPLE_W = 14,
  parameter logic [7:0] AZ_RESET = 8'h01
)
(
  // clock and control
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_ce,
  // register port
  input  wire acfg_wr_t              i_wr,
  input  wire logic [7:0]            i_rd_addr,
  output logic      [7:0]            o_rd_data,
  // analog controls
  output logic                       o_single_ended_input_sel,
  output logic                       o_sample_time_loop_off,
  output logic                       o_autozero_on,
  // mapping load
  output logic                       o_bitmap_load_pulse,
  // sample stream
  input  wire logic [SAMPLE_W-1:0]   i_sample,
  output logic      [ACFG_PAT_W-1:0] o_data
);
  // ==========================================================
  // register file
  logic [7:0] analog_q;
  logic [7:0] analog_d;
  logic [7:0] load_q;
  logic [7:0] load_d;
  logic [7:0] pat_lo_q;
  logic [7:0] pat_lo_d;
  logic [7:0] pat_mi_q;
  logic [7:0] pat_mi_d;
  logic [7:0] pat_hi_q;
  logic [7:0] pat_hi_d;
  logic [7:0] rd_q;
  logic [7:0] rd_d;
  logic       pulse_q;
  logic       pulse_d;
  logic       fall;

  // load fires on the falling edge of the bit: one then zero
  assign fall = i_wr.wr && i_wr.addr == ACFG_OFF_LOAD &&
                load_q[ACFG_BIT_LOAD] && !i_wr.data[ACFG_BIT_LOAD];

  always_comb
  begin
    analog_d = analog_q;
    load_d   = load_q;
    pat_lo_d = pat_lo_q;
    pat_mi_d = pat_mi_q;
    pat_hi_d = pat_hi_q;
    pulse_d  = fall;
    if (i_wr.wr)
    begin
      // whole bytes kept, reserved bits included
      case (i_wr.addr)
        ACFG_OFF_ANALOG: analog_d = i_wr.data;
        ACFG_OFF_LOAD:   load_d   = i_wr.data;
        ACFG_OFF_PAT_LO: pat_lo_d = i_wr.data;
        ACFG_OFF_PAT_MI: pat_mi_d = i_wr.data;
        ACFG_OFF_PAT_HI: pat_hi_d = i_wr.data;
        default:         analog_d = analog_q;
      endcase
    end
    if (fall)
    begin
      // the load wipes earlier writes, so it must come last
      analog_d = AZ_RESET;
      pat_lo_d = ACFG_RST_ZERO;
      pat_mi_d = ACFG_RST_ZERO;
      pat_hi_d = ACFG_RST_ZERO;
    end
    case (i_rd_addr)
      ACFG_OFF_ANALOG: rd_d = analog_q;
      ACFG_OFF_LOAD:   rd_d = load_q;
      ACFG_OFF_PAT_LO: rd_d = pat_lo_q;
      ACFG_OFF_PAT_MI: rd_d = pat_mi_q;
      ACFG_OFF_PAT_HI: rd_d = pat_hi_q;
      default:         rd_d = ACFG_RST_ZERO;
    endcase
  end

  always_ff @(posedge i_core_clk)
  begin
    if (i_rst)
    begin
      analog_q <= AZ_RESET;
      load_q   <= ACFG_RST_ZERO;
      pat_lo_q <= ACFG_RST_ZERO;
      pat_mi_q <= ACFG_RST_ZERO;
      pat_hi_q <= ACFG_RST_ZERO;
      rd_q     <= ACFG_RST_ZERO;
      pulse_q  <= 1'b0;
    end
    else if (i_ce)
    begin
      analog_q <= analog_d;
      load_q   <= load_d;
      pat_lo_q <= pat_lo_d;
      pat_mi_q <= pat_mi_d;
      pat_hi_q <= pat_hi_d;
      rd_q     <= rd_d;
      pulse_q  <= pulse_d;
    end
  end

  // ==========================================================
  // outputs
  assign o_rd_data                = rd_q;
  assign o_single_ended_input_sel = analog_q[ACFG_BIT_SE];
  assign o_sample_time_loop_off   = analog_q[ACFG_BIT_LOOP_OFF];
  assign o_autozero_on            = analog_q[ACFG_BIT_AZ];
  assign o_bitmap_load_pulse      = pulse_q;

  // ==========================================================
  // pattern generator
  acfgtp_pattern_gen #(
    .SAMPLE_W (SAMPLE_W)
  ) u_gen (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_ce       (i_ce),
    .i_sel      (pat_hi_q[ACFG_SEL_MSB:ACFG_SEL_LSB]),
    .i_value    ({pat_hi_q[1:0], pat_mi_q, pat_lo_q}),
    .i_sample   (i_sample),
    .o_data     (o_data)
  );

  // ==========================================================
  // checks: sequences
  // one step of each multi-step behaviour, reused by the properties
  sequence s_load_fall;
    i_ce && fall;
  endsequence

  sequence s_analog_write;
    i_ce && i_wr.wr && i_wr.addr == ACFG_OFF_ANALOG;
  endsequence

  sequence s_hi_write;
    i_ce && i_wr.wr && i_wr.addr == ACFG_OFF_PAT_HI;
  endsequence

  // a write in the read cycle would land after the readback, not shift it
  sequence s_hi_read;
    i_ce && i_rd_addr == ACFG_OFF_PAT_HI && !i_wr.wr;
  endsequence

  // ==========================================================
  // checks: mapping load
  chk_load_pulse: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    s_load_fall |=> o_bitmap_load_pulse)
    else $error("load pulse missing");

  // the load register keeps its own value, which ends the pulse
  chk_load_clears: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    s_load_fall |=> analog_q == AZ_RESET && pat_lo_q == ACFG_RST_ZERO &&
      pat_mi_q == ACFG_RST_ZERO && pat_hi_q == ACFG_RST_ZERO)
    else $error("load did not clear config");

  // a frozen clock enable holds the pulse, so only live cycles count
  chk_no_spurious: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && !fall |=> !o_bitmap_load_pulse)
    else $error("spurious load pulse");

  chk_pulse_single: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    i_ce && o_bitmap_load_pulse |=> !o_bitmap_load_pulse)
    else $error("load pulse longer than one cycle");

  // ==========================================================
  // checks: analog controls and readback
  // each analog bit lands on its pin one cycle after the write
  chk_se_write: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    s_analog_write
    |=> o_single_ended_input_sel == $past(i_wr.data[ACFG_BIT_SE]))
    else $error("single-ended bit not stored");

  chk_loop_write: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    s_analog_write
    |=> o_sample_time_loop_off == $past(i_wr.data[ACFG_BIT_LOOP_OFF]))
    else $error("loop-off bit not stored");

  chk_az_write: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    s_analog_write
    |=> o_autozero_on == $past(i_wr.data[ACFG_BIT_AZ]))
    else $error("auto-zero bit not stored");

  chk_reserved_keep: assert property (
    @(posedge i_core_clk) disable iff (i_rst)
    s_hi_write ##1 s_hi_read
    |=> o_rd_data == $past(i_wr.data, 2))
    else $error("readback mismatch");

  // no disable here: the check looks at the cycle right after reset
  chk_az_reset: assert property (
    @(posedge i_core_clk)
    $past(i_rst) |-> o_autozero_on == AZ_RESET[ACFG_BIT_AZ])
    else $error("auto-zero reset value wrong");
endmodule : acfgtp_regs

// [test/acfgtp_host_model.sv]
`timescale 1ns/1ps
// ==========================================================
// host side of the register port
module acfgtp_host_model
  import acfgtp_pkg::*;
(
  // clock
  input  wire logic       i_core_clk,
  // register port
  output acfg_wr_t        o_wr,
  output logic [7:0]      o_rd_addr,
  input  wire logic [7:0] i_rd_data
);
  initial
  begin
    o_wr = '0;
    o_rd_addr = 8'h00;
  end
  // strobe drops after each write, so an edge passes between requests
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    #1;
    o_wr = '{wr: 1'b1, addr: a, data: d};
    @(posedge i_core_clk);
    #1;
    o_wr.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_core_clk);
    #1;
    o_rd_addr = a;
    @(posedge i_core_clk);
    #1;
    d = i_rd_data;
  endtask : rd
  // one then zero; configuration written before it is cleared
  task automatic load();
    wr(ACFG_OFF_LOAD, 8'h01);
    wr(ACFG_OFF_LOAD, 8'h00);
  endtask : load
endmodule : acfgtp_host_model

// [test/adc_config_test_pattern_test.sv]
`timescale 1ns/1ps
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  errors++; $display("Error %s exp %h got %h", n, e, s); end end
// ==========================================================
// bench top
module adc_config_test_pattern_test;
  import acfgtp_pkg::*;
  logic                  clk;
  logic                  rst;
  logic                  ce;
  acfg_wr_t              wr;
  logic [7:0]            rd_addr;
  logic [7:0]            rd_data;
  logic                  se;
  logic                  loop_off;
  logic                  az;
  logic                  pulse;
  logic [13:0]           sample;
  logic [ACFG_PAT_W-1:0] data;
  logic [ACFG_PAT_W-1:0] a;
  logic [7:0]            v;
  logic [2:0]            codes [5] = '{3'b000, 3'b001, 3'b011, 3'b100, 3'b111};
  int                    errors;
  int                    total_checks;
  int                    pulses;
  acfgtp_regs #(.SAMPLE_W(14), .AZ_RESET(8'h01)) dut_u (
    .i_core_clk(clk), .i_rst(rst), .i_ce(ce), .i_wr(wr),
    .i_rd_addr(rd_addr), .o_rd_data(rd_data),
    .o_single_ended_input_sel(se), .o_sample_time_loop_off(loop_off),
    .o_autozero_on(az), .o_bitmap_load_pulse(pulse),
    .i_sample(sample), .o_data(data));
  acfgtp_host_model host_u (.i_core_clk(clk), .o_wr(wr),
    .o_rd_addr(rd_addr), .i_rd_data(rd_data));
  task automatic summarize();
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // count at the falling edge, away from the edge that moves the pulse
  always @(negedge clk)
  begin
    if (pulse === 1'b1)
      pulses++;
  end
  // watchdog so a stuck run still reports
  initial
  begin
    #20000;
    errors++;
    summarize();
  end
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    sample = 14'h1abc;
    tick(4);
    rst = 1'b0;
    host_u.rd(ACFG_OFF_ANALOG, v);
    `CHK("analog reset", 8'h01, v)
    `CHK("autozero reset", 1'b1, az)
    host_u.wr(ACFG_OFF_PAT_LO, 8'h55);
    host_u.load();
    tick(2);
    `CHK("load pulses", 1, pulses)
    host_u.rd(ACFG_OFF_PAT_LO, v);
    `CHK("low cleared", 8'h00, v)
    host_u.wr(ACFG_OFF_ANALOG, 8'he5);
    tick(1);
    `CHK("single ended", 1'b1, se)
    `CHK("loop off", 1'b1, loop_off)
    host_u.rd(ACFG_OFF_ANALOG, v);
    `CHK("reserved readback", 8'he5, v)
    host_u.wr(ACFG_OFF_ANALOG, 8'h00);
    tick(1);
    `CHK("autozero off", 1'b0, az)
    `CHK("differential", 1'b0, se)
    host_u.load();
    host_u.rd(ACFG_OFF_ANALOG, v);
    `CHK("analog after load", 8'h01, v)
    `CHK("load pulses", 2, pulses)
    host_u.rd(8'h20, v);
    `CHK("unmapped read", 8'h00, v)
    host_u.wr(ACFG_OFF_PAT_LO, 8'h34);
    host_u.wr(ACFG_OFF_PAT_MI, 8'h12);
    foreach (codes[i])
    begin
      host_u.wr(ACFG_OFF_PAT_HI, {3'b000, codes[i], 2'b10});
      tick(3);
      a = (codes[i] == 3'b011) ? 18'h21234 : {sample, 4'h0};
      `CHK("pattern out", a, data)
      host_u.rd(ACFG_OFF_PAT_HI, v);
      `CHK("select readback", {3'b000, codes[i], 2'b10}, v)
    end
    // ramp step of one native lsb at the msb-aligned output
    host_u.wr(ACFG_OFF_PAT_LO, 8'h10);
    host_u.wr(ACFG_OFF_PAT_MI, 8'h00);
    host_u.wr(ACFG_OFF_PAT_HI, 8'h08);
    tick(4);
    a = data;
    tick(1);
    `CHK("ramp step", 18'h00010, data - a)
    `CHK("ramp value", 18'h00040, data)
    // clock enable low freezes the accumulator and the output
    ce = 1'b0;
    tick(3);
    `CHK("ce freeze", 18'h00040, data)
    ce = 1'b1;
    tick(1);
    `CHK("ramp resume", 18'h00050, data)
    summarize();
  end
endmodule : adc_config_test_pattern_test
